// File: rtl/pdc_pkg.sv
// package with register map, field layout, reset values and state codes
package pdc_pkg;
    // register index as printed; byte address is four times it
    localparam logic [7:0] PDC_CTRL_IDX = 8'h03;
    localparam logic [9:0] PDC_CTRL_ADDR = 10'h00C;
    // field positions
    localparam int PDC_PADIO_LSB = 6;
    localparam int PDC_CLKPAD_LSB = 4;
    localparam int PDC_SHIFT_BIT = 3;
    localparam int PDC_RATE_LSB = 0;
    // reset value of the control register
    localparam logic [7:0] PDC_CTRL_RST = 8'h19;
    // transceiver state codes, one-hot
    typedef enum logic [3:0]
    {
        PDC_ST_PON = 4'h1,
        PDC_ST_OFF = 4'h2,
        PDC_ST_ON = 4'h4,
        PDC_ST_SLEEP = 4'h8
    } pdc_state_t;
endpackage

// File: rtl/pdc_sync.sv
// two flip-flop synchroniser for a group of level inputs
`timescale 1ns/1ps
module pdc_sync
#(
    parameter int W = 4
)
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed
    {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } pdc_sync_t;
    pdc_sync_t r;
    pdc_sync_t next_r;

    // first stage is read only by the second
    always_comb
    begin
        next_r.s1 = din;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign dout = r.s2;
endmodule

// File: rtl/pad_drive_config.sv
// pad drive control register with state-dependent pad and supply control
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
module pad_drive_config
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [3:0] trxState,
    input wire logic extSupplySel,
    output logic [1:0] dataPadDrive,
    output logic [1:0] clockPadDrive,
    output logic clockOutShiftSel,
    output logic [2:0] clockOutRateSel,
    output logic resetPullUp,
    output logic selectPullUp,
    output logic sclkPullDown,
    output logic mosiPullDown,
    output logic sleepTxPullDown,
    output logic analogRegEn,
    output logic digitalRegEn,
    output logic rfGroundEn
);
    typedef struct packed
    {
        logic [7:0] ctrl;
        logic [31:0] rdata;
        logic ack;
        logic [1:0] dpad;
        logic [1:0] cpad;
        logic shift;
        logic [2:0] rate;
        logic pullsOn;
        logic aReg;
        logic dReg;
        logic rfGnd;
    } pdc_regs_t;

    pdc_regs_t r;
    pdc_regs_t next_r;
    logic [3:0] stateSync;
    logic extSync;
    logic [7:0] wrCtrl;
    logic hit;
    logic take;

    ////////////////////////////////////////////////////////////////////////
    // state and strap inputs come from another domain
    pdc_sync #(.W(5)) u_sync
    (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .din({extSupplySel, trxState}),
        .dout({extSync, stateSync})
    );

    // decode of one state code, reused for every state test
    function automatic logic inState(input logic [3:0] s,
                                     input pdc_pkg::pdc_state_t st);
        inState = (s == st);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // bus decode; the register lives in byte lane 0 only
    assign hit = (wb_adr_i == pdc_pkg::PDC_CTRL_ADDR);
    assign take = wb_cyc_i && wb_stb_i && !r.ack;
    assign wrCtrl = (take && wb_we_i && hit && wb_sel_i[0]) ?
        wb_dat_i[7:0] : r.ctrl;

    // next-state logic for register, bus answer and pad controls
    always_comb
    begin
        next_r = r;
        next_r.ack = take;
        next_r.ctrl = wrCtrl;
        // unmapped addresses answer with zero rather than stalling
        next_r.rdata = 32'h0000_0000;
        if (take && !wb_we_i && hit)
        begin
            next_r.rdata = {24'h00_0000, r.ctrl};
        end
        // drive codes follow the written value in the same edge
        next_r.dpad = wrCtrl[pdc_pkg::PDC_PADIO_LSB +: 2];
        next_r.cpad = wrCtrl[pdc_pkg::PDC_CLKPAD_LSB +: 2];
        next_r.shift = wrCtrl[pdc_pkg::PDC_SHIFT_BIT];
        next_r.rate = wrCtrl[pdc_pkg::PDC_RATE_LSB +: 3];
        next_r.pullsOn = inState(stateSync, pdc_pkg::PDC_ST_PON);
        // regulators: digital up whenever awake, analog only when on;
        // an external supply takes both over
        next_r.dReg = !extSync &&
            !inState(stateSync, pdc_pkg::PDC_ST_SLEEP);
        next_r.aReg = !extSync &&
            inState(stateSync, pdc_pkg::PDC_ST_ON);
        next_r.rfGnd = inState(stateSync, pdc_pkg::PDC_ST_OFF);
    end

    // reset holds the pulls on, as the device powers up in P-on
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            r.ctrl <= pdc_pkg::PDC_CTRL_RST;
            r.rdata <= 32'h0000_0000;
            r.ack <= 1'b0;
            r.dpad <= 2'h0;
            r.cpad <= 2'h1;
            r.shift <= 1'b1;
            r.rate <= 3'h1;
            r.pullsOn <= 1'b1;
            r.aReg <= 1'b0;
            r.dReg <= 1'b0;
            r.rfGnd <= 1'b0;
        end
        else
        begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from flip-flops
    assign wb_dat_o = r.rdata;
    assign wb_ack_o = r.ack;
    assign dataPadDrive = r.dpad;
    assign clockPadDrive = r.cpad;
    assign clockOutShiftSel = r.shift;
    assign clockOutRateSel = r.rate;
    // each pull follows the same state flag; direction is fixed per pin
    assign resetPullUp = r.pullsOn;
    assign selectPullUp = r.pullsOn;
    assign sclkPullDown = r.pullsOn;
    assign mosiPullDown = r.pullsOn;
    assign sleepTxPullDown = r.pullsOn;
    assign analogRegEn = r.aReg;
    assign digitalRegEn = r.dReg;
    assign rfGroundEn = r.rfGnd;

    ////////////////////////////////////////////////////////////////////////
    // checks
    logic wrDone;
    assign wrDone = wb_cyc_i && wb_stb_i && wb_we_i && hit && wb_sel_i[0]
        && !r.ack;

    data_drive_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        wrDone |=> dataPadDrive == $past(wb_dat_i[7:6]))
        else $error("data pad drive not updated");
    clk_drive_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        wrDone |=> clockPadDrive == $past(wb_dat_i[5:4]))
        else $error("clock pad drive not updated");
    ctrl_read_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        wrDone ##1 (wb_cyc_i && wb_stb_i && !wb_we_i && hit && !r.ack)
        |=> wb_dat_o[7:0] == $past(wb_dat_i[7:0], 2))
        else $error("control readback mismatch");
    pull_state_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (stateSync == pdc_pkg::PDC_ST_PON) |=> resetPullUp)
        else $error("pulls off in power-on state");
    pull_off_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (stateSync != pdc_pkg::PDC_ST_PON) |=> !sclkPullDown)
        else $error("pulls on outside power-on");
    pull_same_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        selectPullUp == mosiPullDown && sleepTxPullDown == resetPullUp)
        else $error("pull set inconsistent");
    reg_ext_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        extSync |=> !analogRegEn && !digitalRegEn)
        else $error("regulator on with external supply");
    reg_state_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (!extSync && stateSync == pdc_pkg::PDC_ST_OFF)
        |=> digitalRegEn && !analogRegEn)
        else $error("regulator enables wrong in off state");
    rf_ground_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (stateSync == pdc_pkg::PDC_ST_OFF) |=> rfGroundEn)
        else $error("rf pins not grounded in off state");
    ack_pulse_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    wr_cov_c: cover property (@(posedge sys_clk) disable iff (!nrst)
        wrDone);
    rd_cov_c: cover property (@(posedge sys_clk) disable iff (!nrst)
        wb_ack_o && !wb_we_i && hit);
    off_cov_c: cover property (@(posedge sys_clk) disable iff (!nrst)
        rfGroundEn);
    pon_cov_c: cover property (@(posedge sys_clk) disable iff (!nrst)
        $fell(resetPullUp));
endmodule

// File: bench/pdc_host.sv
// host model: classic wishbone master reaching the pad control register
`timescale 1ns/1ps
module pdc_host
(
    input wire logic sys_clk,
    input wire logic ack,
    input wire logic [31:0] rdat,
    output logic cyc,
    output logic stb,
    output logic we,
    output logic [9:0] adr,
    output logic [3:0] sel,
    output logic [31:0] dat
);
    initial {cyc, stb, we, adr, sel, dat} = '0;
    ////////////////////////////////////////////////////////////////////////
    // request held until ack is sampled; bounded wait guards against a hang
    task automatic xfer(input logic w, input logic [9:0] a,
        input logic [3:0] s, input logic [31:0] d,
        output logic [31:0] q, output logic ok);
        int n;
        n = 0;
        @(posedge sys_clk);
        {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, d};
        do
            @(posedge sys_clk);
        while (ack !== 1'b1 && ++n < 20);
        q = rdat;
        ok = (ack === 1'b1);
        // released data lines show the inverse so stale values never match
        {cyc, stb, dat} <= {2'b00, ~d};
    endtask
endmodule

// File: bench/pad_drive_config_test.sv
// self-checking bench for the pad drive control block
`timescale 1ns/1ps
module pad_drive_config_test;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic cyc, stb, we, ack, extSupplySel, shf, rpu, spu, scd, mod, sld;
    logic [9:0] adr;
    logic [3:0] sel;
    logic [3:0] trxState = 4'h1;
    logic [31:0] wdat, rdat, q;
    logic [1:0] dpd, cpd;
    logic [2:0] rate;
    logic aReg, dReg, rfg, ok;
    int mismatches = 0;
    int checked = 0;
    int seed = 32'h6A41;
    logic [7:0] cur, d;
    always #5 sys_clk = ~sys_clk;
    initial extSupplySel = 1'b0;
    pad_drive_config i_pad_drive_config (.sys_clk(sys_clk), .nrst(nrst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .trxState(trxState), .extSupplySel(extSupplySel),
        .dataPadDrive(dpd), .clockPadDrive(cpd), .clockOutShiftSel(shf),
        .clockOutRateSel(rate), .resetPullUp(rpu), .selectPullUp(spu),
        .sclkPullDown(scd), .mosiPullDown(mod), .sleepTxPullDown(sld),
        .analogRegEn(aReg), .digitalRegEn(dReg), .rfGroundEn(rfg));
    pdc_host i_pdc_host (.sys_clk(sys_clk), .ack(ack), .rdat(rdat),
        .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(wdat));
    ////////////////////////////////////////////////////////////////////////
    // one comparison; a miss is reported at once
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // bus cycle; a lost ack ends the run
    task automatic bus(input logic w, input logic [9:0] a,
        input logic [3:0] s, input logic [31:0] v);
        i_pdc_host.xfer(w, a, s, v, q, ok);
        if (!ok)
        begin
            mismatches++;
            give_verdict();
        end
    endtask
    // expected pull, ground and regulator outputs for a state
    function automatic logic [7:0] padExp(input logic [3:0] s,
        input logic e);
        logic p;
        p = (s == pdc_pkg::PDC_ST_PON);
        return {p, p, p, p, p, s == pdc_pkg::PDC_ST_OFF,
            s == pdc_pkg::PDC_ST_ON && !e, s != pdc_pkg::PDC_ST_SLEEP && !e};
    endfunction
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        chk({dpd, cpd, shf, rate}, pdc_pkg::PDC_CTRL_RST);
        bus(1'b0, pdc_pkg::PDC_CTRL_ADDR, 4'hF, 32'h0);
        chk(q, 32'h19);
        $display("reset test done");
        // corners first, then random codes; fields must follow at once
        for (int i = 0; i < 10; i++)
        begin
            d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
            bus(1'b1, pdc_pkg::PDC_CTRL_ADDR, 4'h1, {24'hABCDEF, d});
            chk({dpd, cpd, shf, rate}, d);
            bus(1'b0, pdc_pkg::PDC_CTRL_ADDR, 4'hF, 32'h0);
            chk(q, {24'h0, d});
        end
        $display("write test done");
        // byte lane off and foreign address leave the register alone
        cur = d;
        bus(1'b1, pdc_pkg::PDC_CTRL_ADDR, 4'hE, 32'h0000005A);
        bus(1'b1, 10'h010, 4'h1, 32'h000000A5);
        chk({dpd, cpd, shf, rate}, cur);
        bus(1'b0, 10'h010, 4'hF, 32'h0);
        chk(q, 32'h0);
        $display("refusal test done");
        // every state with and without the external supply
        for (int i = 0; i < 8; i++)
        begin
            @(posedge sys_clk);
            trxState <= 4'h1 << (i % 4);
            extSupplySel <= (i >= 4);
            repeat (5) @(posedge sys_clk);
            chk({rpu, spu, scd, mod, sld, rfg, aReg, dReg},
                padExp(trxState, extSupplySel));
        end
        chk({dpd, cpd, shf, rate}, cur);
        $display("state test done");
        give_verdict();
    end
endmodule
